// [hdl/dfs_pkg.sv]
// Shared constants for the drive fault supervisor
package dfs_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam int FLASH_PERIOD_MS = 1000;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_PERIOD_MS;
    localparam int NUM_SRC = 12;
    localparam int DC_LINK_LIMIT_V = 480;
    localparam logic [9:0] DC_LINK_LIMIT = 10'h01E0;
    // Fault source indices, equal to the fault code number
    localparam int SRC_HW = 0;
    localparam int SRC_SUPPLY = 1;
    localparam int SRC_CABLE = 3;
    localparam int SRC_DCLINK = 4;
    localparam int SRC_CURR = 5;
    localparam int SRC_BALLAST = 6;
    localparam int SRC_AMP_TEMP = 7;
    localparam int SRC_MOT_TEMP = 8;
    localparam int SRC_ENC = 9;
    localparam int SRC_SPEED = 10;
    localparam int SRC_TRANS = 11;
    // Display characters
    localparam logic [3:0] CH_F = 4'hF;
    localparam logic [3:0] CH_BLANK = 4'hE;
    // Display phase codes
    typedef enum logic [1:0] {
        DFS_PH_LETTER = 2'b00,
        DFS_PH_TENS = 2'b01,
        DFS_PH_UNITS = 2'b10,
        DFS_PH_GAP = 2'b11
    } dfs_phase_t;
endpackage

// [hdl/dfs_flasher.sv]
// Sequencer that shows letter, tens digit, units digit each period
module dfs_flasher #(
    parameter int PERIOD = dfs_pkg::FLASH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic active,
    input wire logic [3:0] code,
    output logic [3:0] disp_char,
    output logic disp_on
);
    localparam int STEP = PERIOD / 4;
    if (PERIOD < 8) begin : g_bad_period
        $error("PERIOD too small");
    end
    logic [31:0] cnt_r, cnt_nxt;
    dfs_pkg::dfs_phase_t ph_r, ph_nxt;
    logic [3:0] ch_r, ch_nxt;
    logic on_r, on_nxt;
    logic [3:0] tens, units;

    always_comb begin
        tens = (code >= 4'hA) ? 4'h1 : 4'h0;
        units = (code >= 4'hA) ? code - 4'hA : code;
        cnt_nxt = cnt_r + 32'h0000_0001;
        ph_nxt = ph_r;
        if (!active) begin
            cnt_nxt = '0;
            ph_nxt = dfs_pkg::DFS_PH_LETTER;
        end else if (cnt_r == 32'(STEP - 1)) begin
            cnt_nxt = '0;
            ph_nxt = dfs_pkg::dfs_phase_t'(ph_r + 2'b01);
        end
        on_nxt = active;
        unique case (ph_nxt)
            dfs_pkg::DFS_PH_LETTER: ch_nxt = dfs_pkg::CH_F;
            dfs_pkg::DFS_PH_TENS: ch_nxt = tens;
            dfs_pkg::DFS_PH_UNITS: ch_nxt = units;
            dfs_pkg::DFS_PH_GAP: ch_nxt = dfs_pkg::CH_BLANK;
        endcase
        if (!active) ch_nxt = dfs_pkg::CH_BLANK;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cnt_r <= '0;
            ph_r <= dfs_pkg::DFS_PH_LETTER;
            ch_r <= dfs_pkg::CH_BLANK;
            on_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ph_r <= ph_nxt;
            ch_r <= ch_nxt;
            on_r <= on_nxt;
        end
    end
    assign disp_char = ch_r;
    assign disp_on = on_r;

    a_letter_first: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(on_r) |-> ch_r == dfs_pkg::CH_F) // [RULE1]
        else $error("display did not start with letter");
endmodule

// [hdl/dfs_top.sv]
// Fault supervisor: latches faults, picks reaction, drives display
//
// Function
// (RULE1) Flash F and two code digits each second
// (RULE2) Hardware or supply fault disables pulses
// (RULE3) Cable break checked at first enable, code 03
// (RULE4) DC link above 480 V locks, code 04
// (RULE5) Ballast, amp, motor heat lock, codes 06-08
// (RULE6) Encoder failure locks, code 09
// (RULE7) Transient overcurrent locks, code 11
// (RULE8) Controller acknowledges thermal faults after cooling
// (RULE9) Locking fault enters malfunction state F
// (RULE10) Pulse faults sticky; lock faults ack-cleared
module dfs_top #(
    parameter int FLASH_CYCLES = dfs_pkg::FLASH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic hw_defect,
    input wire logic supply_fault,
    input wire logic cable_broken,
    input wire logic [9:0] dc_link_volts,
    input wire logic over_current,
    input wire logic ballast_overload,
    input wire logic amp_overtemp,
    input wire logic motor_overtemp,
    input wire logic encoder_fault,
    input wire logic over_speed,
    input wire logic transient_current,
    input wire logic enable_cmd,
    input wire logic fault_ack,
    output logic pulse_enable,
    output logic ctrl_locked,
    output logic malfunction,
    output logic fault_pending,
    output logic [3:0] fault_code,
    output logic [3:0] disp_char,
    output logic disp_on
);
    localparam int N = dfs_pkg::NUM_SRC;
    if (FLASH_CYCLES < 8) begin : g_bad_flash
        $error("FLASH_CYCLES too small");
    end

    typedef enum logic [1:0] {
        DFS_ST_RUN = 2'b00,
        DFS_ST_LOCK = 2'b01,
        DFS_ST_PULSE_OFF = 2'b10
    } dfs_state_t;

    logic [N-1:0] cause;
    logic [N-1:0] lat_r, lat_nxt;
    logic first_en_r, first_en_nxt;
    logic en_d_r;
    dfs_state_t st_r, st_nxt;
    logic [3:0] code_r, code_nxt;
    logic pulse_flt, lock_flt;
    logic cable_check;

    // Cable test only on the first rising enable after reset
    assign cable_check = enable_cmd && !en_d_r && !first_en_r;

    always_comb begin
        cause = '0;
        cause[dfs_pkg::SRC_HW] = hw_defect;
        cause[dfs_pkg::SRC_SUPPLY] = supply_fault;
        cause[dfs_pkg::SRC_CABLE] = cable_check && cable_broken; // [RULE3]
        cause[dfs_pkg::SRC_DCLINK] =
            dc_link_volts > dfs_pkg::DC_LINK_LIMIT; // [RULE4]
        cause[dfs_pkg::SRC_CURR] = over_current;
        cause[dfs_pkg::SRC_BALLAST] = ballast_overload; // [RULE5]
        cause[dfs_pkg::SRC_AMP_TEMP] = amp_overtemp; // [RULE5]
        cause[dfs_pkg::SRC_MOT_TEMP] = motor_overtemp; // [RULE5]
        cause[dfs_pkg::SRC_ENC] = encoder_fault; // [RULE6]
        cause[dfs_pkg::SRC_SPEED] = over_speed;
        cause[dfs_pkg::SRC_TRANS] = transient_current; // [RULE7]
    end

    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_lat
            always_comb begin
                if (cause[gi]) begin
                    lat_nxt[gi] = 1'b1; // Set wins over ack
                end else if (fault_ack && gi > dfs_pkg::SRC_SUPPLY) begin
                    lat_nxt[gi] = 1'b0; // [RULE10]
                end else begin
                    lat_nxt[gi] = lat_r[gi];
                end
            end
        end
    endgenerate

    always_comb begin
        pulse_flt = lat_nxt[dfs_pkg::SRC_HW] ||
            lat_nxt[dfs_pkg::SRC_SUPPLY];
        lock_flt = |lat_nxt;
        first_en_nxt = first_en_r || cable_check;
        code_nxt = code_r;
        for (int i = N - 1; i >= 0; i--) begin
            if (lat_nxt[i]) code_nxt = 4'(i);
        end
        if (!lock_flt) code_nxt = 4'h0;
        unique case (st_r)
            DFS_ST_RUN, DFS_ST_LOCK: begin
                if (pulse_flt) st_nxt = DFS_ST_PULSE_OFF; // [RULE2]
                else if (lock_flt) st_nxt = DFS_ST_LOCK; // [RULE9]
                else st_nxt = DFS_ST_RUN;
            end
            DFS_ST_PULSE_OFF: st_nxt = DFS_ST_PULSE_OFF; // [RULE10]
            default: st_nxt = DFS_ST_PULSE_OFF;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            lat_r <= '0;
            first_en_r <= 1'b0;
            en_d_r <= 1'b0;
            st_r <= DFS_ST_RUN;
            code_r <= 4'h0;
        end else begin
            lat_r <= lat_nxt;
            first_en_r <= first_en_nxt;
            en_d_r <= enable_cmd;
            st_r <= st_nxt;
            code_r <= code_nxt;
        end
    end

    assign pulse_enable = (st_r == DFS_ST_RUN) && enable_cmd;
    assign ctrl_locked = st_r != DFS_ST_RUN;
    assign malfunction = st_r == DFS_ST_LOCK; // [RULE9]
    assign fault_pending = |lat_r;
    assign fault_code = code_r;

    dfs_flasher #(
        .PERIOD(FLASH_CYCLES)
    ) u_flash (
        .sys_clk(sys_clk),
        .srst(srst),
        .active(fault_pending), // [RULE1]
        .code(code_r),
        .disp_char(disp_char),
        .disp_on(disp_on)
    );

    a_pulse_off: assert property (@(posedge sys_clk) disable iff (srst)
        (hw_defect || supply_fault) |=> !pulse_enable) // [RULE2]
        else $error("pulses not disabled");
    a_pulse_sticky: assert property (@(posedge sys_clk) disable iff (srst)
        st_r == DFS_ST_PULSE_OFF |=> st_r == DFS_ST_PULSE_OFF) // [RULE10]
        else $error("pulse disable cleared");
    a_dclink_lock: assert property (@(posedge sys_clk) disable iff (srst)
        dc_link_volts > dfs_pkg::DC_LINK_LIMIT |=>
        ctrl_locked && lat_r[dfs_pkg::SRC_DCLINK]) // [RULE4]
        else $error("dc link overvoltage not locked");
    a_thermal_lock: assert property (@(posedge sys_clk) disable iff (srst)
        (ballast_overload || amp_overtemp || motor_overtemp) |=>
        ctrl_locked) // [RULE5]
        else $error("thermal fault not locked");
    a_encoder_lock: assert property (@(posedge sys_clk) disable iff (srst)
        encoder_fault |=> lat_r[dfs_pkg::SRC_ENC] && ctrl_locked) // [RULE6]
        else $error("encoder fault not locked");
    a_trans_lock: assert property (@(posedge sys_clk) disable iff (srst)
        transient_current |=> lat_r[dfs_pkg::SRC_TRANS]) // [RULE7]
        else $error("transient current not latched");
    a_cable_once: assert property (@(posedge sys_clk) disable iff (srst)
        first_en_r |=> !cause[dfs_pkg::SRC_CABLE]) // [RULE3]
        else $error("cable checked after first enable");
    a_ack_clears: assert property (@(posedge sys_clk) disable iff (srst)
        fault_ack && !(|cause) && !lat_r[0] && !lat_r[1] |=>
        !fault_pending && st_r == DFS_ST_RUN) // [RULE10]
        else $error("ack did not clear locking faults");
    a_malf_state: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(lat_r[dfs_pkg::SRC_CABLE]) && !lat_r[0] && !lat_r[1] |->
        malfunction) // [RULE9]
        else $error("malfunction state not entered");
endmodule

// [verification/dfs_ctrl_model.sv]
// Operating controller model: drive enable and fault acknowledge
module dfs_ctrl_model (
    input wire logic sys_clk,
    input wire logic want_en,
    input wire logic want_ack,
    input wire logic cooled,
    input wire logic early,
    output logic enable_cmd,
    output logic fault_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        enable_cmd = 1'b0;
        fault_ack = 1'b0;
    end
    always @(posedge sys_clk) begin
        enable_cmd <= want_en;
        // Holds off acknowledge until cooled, unless told to force it
        fault_ack <= want_ack & (cooled | early);
    end
endmodule

// [verification/drive_fault_supervisor_bench.sv]
// Self-checking bench for the drive fault supervisor
module drive_fault_supervisor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] src = 12'h000;
    logic want_en = 1'b0;
    logic want_ack = 1'b0;
    logic early = 1'b0;
    logic enable_cmd, fault_ack, pulse_enable, ctrl_locked, malfunction;
    logic fault_pending, disp_on;
    logic [3:0] fault_code, disp_char;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    always #10 sys_clk = ~sys_clk;
    dfs_ctrl_model dfs_ctrl_model_i (.sys_clk(sys_clk), .want_en(want_en),
        .want_ack(want_ack), .cooled(src[8:6] == 3'h0), .early(early),
        .enable_cmd(enable_cmd), .fault_ack(fault_ack));
    // Bit 4 selects one volt above the overvoltage limit
    dfs_top #(.FLASH_CYCLES(16)) dfs_top_i (.sys_clk(sys_clk), .srst(srst),
        .hw_defect(src[0]), .supply_fault(src[1]), .cable_broken(src[3]),
        .dc_link_volts(src[4] ? 10'h01E1 : 10'h01E0),
        .over_current(src[5]), .ballast_overload(src[6]),
        .amp_overtemp(src[7]), .motor_overtemp(src[8]),
        .encoder_fault(src[9]), .over_speed(src[10]),
        .transient_current(src[11]), .enable_cmd(enable_cmd),
        .fault_ack(fault_ack), .pulse_enable(pulse_enable),
        .ctrl_locked(ctrl_locked), .malfunction(malfunction),
        .fault_pending(fault_pending), .fault_code(fault_code),
        .disp_char(disp_char), .disp_on(disp_on));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic do_reset(input logic en);
        @(posedge sys_clk);
        srst <= 1'b1;
        src <= 12'h000;
        want_en <= 1'b0;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        want_en <= en;
        tick(3);
    endtask
    task automatic ack(input logic force_it);
        @(posedge sys_clk);
        early <= force_it;
        want_ack <= 1'b1;
        @(posedge sys_clk);
        want_ack <= 1'b0;
        early <= 1'b0;
        tick(3);
    endtask
    task automatic raise(input int c);
        @(posedge sys_clk);
        src[c] <= 1'b1;
        tick(2);
    endtask
    task automatic test_thermal();
        check(pulse_enable, 1'b1);
        raise(8);
        check(fault_code, 4'h8);
        check({pulse_enable, ctrl_locked, malfunction}, 3'b011);
        tick(1);
        check({disp_on, disp_char}, 5'h1F);
        tick(4);
        check(disp_char, 4'h0);
        tick(4);
        check(disp_char, 4'h8);
        tick(4);
        check(disp_char, 4'hE);
        tick(4);
        check(disp_char, 4'hF);
        ack(1'b1);
        check(fault_pending, 1'b1);
        @(posedge sys_clk);
        src[8] <= 1'b0;
        ack(1'b0);
        check({fault_pending, ctrl_locked, disp_on}, 3'b000);
        $display("test thermal done");
    endtask
    task automatic test_locking();
        int codes[7] = '{4, 5, 6, 7, 9, 10, 11};
        check(fault_pending, 1'b0);
        foreach (codes[i]) begin
            raise(codes[i]);
            check(fault_code, codes[i][3:0]);
            check({ctrl_locked, malfunction}, 2'b11);
            if (codes[i] >= 10) begin
                tick(3);
                check(disp_char, 4'h1);
                tick(4);
                check(disp_char, 4'(codes[i] - 10));
            end
            @(posedge sys_clk);
            src[codes[i]] <= 1'b0;
            ack(1'b0);
            check(fault_pending, 1'b0);
        end
        $display("test locking done");
    endtask
    task automatic test_pulse_off();
        for (int c = 0; c < 2; c++) begin
            do_reset(1'b1);
            raise(c);
            check(fault_code, c[3:0]);
            check({pulse_enable, ctrl_locked, malfunction}, 3'b010);
            @(posedge sys_clk);
            src[c] <= 1'b0;
            ack(1'b0);
            check({fault_pending, fault_code}, {1'b1, c[3:0]});
        end
        $display("test pulse off done");
    endtask
    task automatic test_cable();
        do_reset(1'b0);
        @(posedge sys_clk);
        src[3] <= 1'b1;
        want_en <= 1'b1;
        tick(3);
        check({fault_code, ctrl_locked}, 5'h07);
        @(posedge sys_clk);
        src[3] <= 1'b0;
        ack(1'b0);
        check(fault_pending, 1'b0);
        $display("test cable done");
    endtask
    initial begin
        do_reset(1'b1);
        test_thermal();
        test_locking();
        test_pulse_off();
        test_cable();
        tally_and_finish();
    end
endmodule
